// File: ot_defs.svh
// Command codes, field positions, reset values and timing for the over-temperature fault controller
`ifndef OT_DEFS_SVH
`define OT_DEFS_SVH

// ==================================================
// Command codes
`define OT_CMD_CLEAR     8'h03
`define OT_CMD_THRESHOLD 8'h4f
`define OT_CMD_ACTION    8'h50

// ==================================================
// Action register fields
`define OT_RESP_HI       7
`define OT_RESP_LO       6
`define OT_RETRY_HI      5
`define OT_RETRY_LO      3
`define OT_DELAY_HI      2
`define OT_DELAY_LO      0

`define OT_RESP_IGNORE   2'h0
`define OT_RESP_RIDE     2'h1
`define OT_RESP_DISABLE  2'h2
`define OT_RESP_RESUME   2'h3
`define OT_RETRY_NONE    3'h0
`define OT_RETRY_CONT    3'h7

// ==================================================
// Reset values
`define OT_THRESHOLD_RST 16'h0064
`define OT_ACTION_RST    8'hc0

// ==================================================
// Timing
`define OT_CLK_PERIOD_NS 8.0
`define OT_DELAY_UNIT_MS 10.0
`define OT_RETRY_UNIT_MS 8.2
`define OT_NS_PER_MS     1000000.0

`endif

// File: ot_pkg.sv
// Types shared by the over-temperature fault controller
`default_nettype none
package ot_pkg;

    // ==================================================
    // Link side
    typedef enum logic [2:0] {
        L_IDLE  = 3'b000,
        L_RX    = 3'b001,
        L_ACK   = 3'b010,
        L_TX    = 3'b011,
        L_TXACK = 3'b100
    } link_state_t;

    typedef struct packed {
        link_state_t st;
        logic [7:0]  sh;
        logic [3:0]  bitn;
        logic [2:0]  idx;
        logic        rd;
        logic [7:0]  cmd;
        logic [7:0]  d0;
        logic [7:0]  d1;
        logic        sda_oe;
        logic        sda_lvl;
    } link_t;

    // ==================================================
    // Fault side
    typedef enum logic [2:0] {
        F_RUN   = 3'b000,
        F_DELAY = 3'b001,
        F_SPACE = 3'b010,
        F_LATCH = 3'b011,
        F_HOLD  = 3'b100
    } fault_state_t;

    typedef struct packed {
        fault_state_t st;
        logic [2:0]   tries;
        logic [23:0]  timer;
        logic         en;
        logic         status;
        logic         alert_n;
    } fault_t;

endpackage
`default_nettype wire

// File: overtemp_fault_response_ctrl.sv
// Over-temperature fault response controller with its PMBus register slave
`timescale 1ns/10ps
`default_nettype none
`include "ot_defs.svh"

module overtemp_fault_response_ctrl #(
    parameter logic [6:0] BUS_ADDR       = 7'h40,
    parameter int         DELAY_UNIT_CYC = int'(`OT_DELAY_UNIT_MS * `OT_NS_PER_MS / `OT_CLK_PERIOD_NS),
    parameter int         RETRY_UNIT_CYC = int'(`OT_RETRY_UNIT_MS * `OT_NS_PER_MS / `OT_CLK_PERIOD_NS)
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        output_on_cmd,
    input  wire logic [15:0] temperature,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             output_enable_req,
    output logic             alert_line_n,
    output logic             fault_status
);

    // ==================================================
    // Pin synchronisers
    logic scl_s1, scl_s2, scl_q;
    logic sda_s1, sda_s2, sda_q;
    logic on_s1, on_s2;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_q  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_q  <= 1'b1;
            on_s1  <= 1'b0;
            on_s2  <= 1'b0;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_q  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_q  <= sda_s2;
            on_s1  <= output_on_cmd;
            on_s2  <= on_s1;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2 & ~scl_q;
    assign scl_fall  = ~scl_s2 & scl_q;
    assign bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_q & ~sda_q & sda_s2;

    // ==================================================
    // Registers and link
    ot_pkg::link_t link, next_link;
    logic [15:0]   threshold, next_threshold;
    logic [7:0]    action, next_action;
    logic          wr_thr, wr_act, clr;
    logic [15:0]   tx_word;

    // Unmapped commands read back as all ones
    always_comb begin
        if (link.cmd == `OT_CMD_THRESHOLD)
            tx_word = threshold;
        else if (link.cmd == `OT_CMD_ACTION)
            tx_word = {8'h00, action};
        else
            tx_word = 16'hffff;
    end

    always_comb begin
        next_link = link;
        wr_thr    = 1'b0;
        wr_act    = 1'b0;
        clr       = 1'b0;
        if (bus_start) begin
            next_link.st     = ot_pkg::L_RX;
            next_link.bitn   = 4'h0;
            next_link.idx    = 3'h0;
            next_link.rd     = 1'b0;
            next_link.sda_oe = 1'b0;
        end else if (bus_stop) begin
            // Writes commit only on a clean stop, so a torn frame changes nothing
            if (!link.rd && link.st != ot_pkg::L_IDLE) begin
                clr    = (link.idx == 3'h2) && (link.cmd == `OT_CMD_CLEAR);
                wr_act = (link.idx == 3'h3) && (link.cmd == `OT_CMD_ACTION);
                wr_thr = (link.idx == 3'h4) && (link.cmd == `OT_CMD_THRESHOLD);
            end
            next_link.st     = ot_pkg::L_IDLE;
            next_link.sda_oe = 1'b0;
        end else begin
            case (link.st)
                ot_pkg::L_RX: begin
                    if (scl_rise) begin
                        next_link.sh   = {link.sh[6:0], sda_s2};
                        next_link.bitn = 4'(link.bitn + 4'h1);
                    end else if (scl_fall && link.bitn == 4'h8) begin
                        next_link.bitn = 4'h0;
                        next_link.idx  = 3'(link.idx + 3'h1);
                        next_link.st   = ot_pkg::L_ACK;
                        next_link.sda_oe = 1'b1;
                        case (link.idx)
                            3'h0: begin
                                next_link.rd = link.sh[0];
                                if (link.sh[7:1] != BUS_ADDR) begin
                                    next_link.st     = ot_pkg::L_IDLE;
                                    next_link.sda_oe = 1'b0;
                                end
                            end
                            3'h1: next_link.cmd = link.sh;
                            3'h2: next_link.d0 = link.sh;
                            3'h3: next_link.d1 = link.sh;
                            default: begin
                                next_link.st     = ot_pkg::L_IDLE;
                                next_link.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
                ot_pkg::L_ACK: begin
                    if (scl_fall) begin
                        next_link.bitn = 4'h0;
                        if (link.rd) begin
                            next_link.sh     = (link.idx == 3'h1) ? tx_word[7:0] : tx_word[15:8];
                            next_link.sda_oe = (link.idx == 3'h1) ? ~tx_word[7] : ~tx_word[15];
                            next_link.idx    = 3'(link.idx + 3'h1);
                            next_link.st     = ot_pkg::L_TX;
                        end else begin
                            next_link.sda_oe = 1'b0;
                            next_link.st     = ot_pkg::L_RX;
                        end
                    end
                end
                ot_pkg::L_TX: begin
                    if (scl_fall) begin
                        next_link.bitn = 4'(link.bitn + 4'h1);
                        if (link.bitn == 4'h7) begin
                            next_link.sda_oe = 1'b0;
                            next_link.st     = ot_pkg::L_TXACK;
                        end else begin
                            next_link.sh     = {link.sh[6:0], 1'b0};
                            next_link.sda_oe = ~link.sh[6];
                        end
                    end
                end
                ot_pkg::L_TXACK: begin
                    if (scl_rise)
                        next_link.st = sda_s2 ? ot_pkg::L_IDLE : ot_pkg::L_ACK;
                end
                default: next_link.st = ot_pkg::L_IDLE;
            endcase
        end
        next_threshold = wr_thr ? {link.d1, link.d0} : threshold;
        next_action    = wr_act ? link.d0 : action;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link      <= '0;
            threshold <= `OT_THRESHOLD_RST;
            action    <= `OT_ACTION_RST;
        end else begin
            link      <= next_link;
            threshold <= next_threshold;
            action    <= next_action;
        end
    end

    assign sda_oe  = link.sda_oe;
    assign sda_out = link.sda_lvl;

    // ==================================================
    // Fault detection
    function automatic logic signed [47:0] lin_val(input logic [15:0] v);
        logic signed [47:0] m;
        logic signed [5:0]  e;
        m = 48'(signed'(v[10:0]));
        e = 6'(signed'(v[15:11]));
        lin_val = m <<< (e + 6'sd16);
    endfunction

    logic fault;
    assign fault = lin_val(temperature) >= lin_val(threshold);

    logic [1:0]  resp;
    logic [2:0]  retr, dly;
    logic [23:0] delay_load, retry_load;
    assign resp       = action[`OT_RESP_HI:`OT_RESP_LO];
    assign retr       = action[`OT_RETRY_HI:`OT_RETRY_LO];
    assign dly        = action[`OT_DELAY_HI:`OT_DELAY_LO];
    assign delay_load = 24'(DELAY_UNIT_CYC) * {21'h000000, dly};
    assign retry_load = 24'(RETRY_UNIT_CYC) * {21'h000000, dly};

    // ==================================================
    // Fault response sequencer
    ot_pkg::fault_t f, next_f;

    always_comb begin
        next_f = f;
        case (f.st)
            ot_pkg::F_RUN: begin
                if (fault) begin
                    case (resp)
                        `OT_RESP_RIDE: begin
                            next_f.st    = ot_pkg::F_DELAY;
                            next_f.timer = delay_load;
                        end
                        `OT_RESP_DISABLE: begin
                            next_f.tries = 3'h0;
                            next_f.timer = retry_load;
                            next_f.st = (retr == `OT_RETRY_NONE) ? ot_pkg::F_LATCH : ot_pkg::F_SPACE;
                        end
                        `OT_RESP_RESUME: next_f.st = ot_pkg::F_HOLD;
                        default: next_f.st = ot_pkg::F_RUN;
                    endcase
                end
            end
            ot_pkg::F_DELAY: begin
                if (f.timer != 24'h000000)
                    next_f.timer = 24'(f.timer - 24'h000001);
                else if (!fault)
                    next_f.st = ot_pkg::F_RUN;
                else begin
                    next_f.tries = 3'h0;
                    next_f.timer = retry_load;
                    next_f.st = (retr == `OT_RETRY_NONE) ? ot_pkg::F_LATCH : ot_pkg::F_SPACE;
                end
            end
            ot_pkg::F_SPACE: begin
                // Commanding the output off abandons the retry sequence
                if (!on_s2)
                    next_f.st = ot_pkg::F_RUN;
                else if (f.timer != 24'h000000)
                    next_f.timer = 24'(f.timer - 24'h000001);
                else if (!fault)
                    next_f.st = ot_pkg::F_RUN;
                else if (retr != `OT_RETRY_CONT && 3'(f.tries + 3'h1) == retr)
                    next_f.st = ot_pkg::F_LATCH;
                else begin
                    // Reload at the attempt itself so spacing is start to start
                    next_f.timer = retry_load;
                    if (retr != `OT_RETRY_CONT)
                        next_f.tries = 3'(f.tries + 3'h1);
                end
            end
            ot_pkg::F_HOLD: begin
                if (!fault)
                    next_f.st = ot_pkg::F_RUN;
            end
            ot_pkg::F_LATCH: begin
                if (clr)
                    next_f.st = ot_pkg::F_RUN;
            end
            default: next_f.st = ot_pkg::F_RUN;
        endcase
        next_f.en = on_s2 && (next_f.st == ot_pkg::F_RUN || next_f.st == ot_pkg::F_DELAY);
        // A fault in the clearing cycle keeps the bit set
        next_f.status  = fault | (f.status & ~clr);
        next_f.alert_n = ~next_f.status;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            f         <= '0;
            f.alert_n <= 1'b1;
        end else begin
            f <= next_f;
        end
    end

    assign output_enable_req = f.en;
    assign alert_line_n      = f.alert_n;
    assign fault_status      = f.status;

    // ==================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_thr_write;
        wr_thr |=> threshold == $past({link.d1, link.d0});
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

    property p_act_write;
        wr_act |=> action == $past(link.d0);
    endproperty
    a_act_write: assert property (p_act_write) else $error("action write lost");

    property p_ignore;
        (f.st == ot_pkg::F_RUN && resp == `OT_RESP_IGNORE && on_s2) |=> output_enable_req;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored fault dropped output");

    property p_ride;
        (f.st == ot_pkg::F_RUN && fault && resp == `OT_RESP_RIDE && on_s2)
            |=> f.st == ot_pkg::F_DELAY && output_enable_req && f.timer == $past(delay_load);
    endproperty
    a_ride: assert property (p_ride) else $error("ride-through not started");

    property p_disable;
        // A zero spacing lets the first attempt restart the output on the second edge
        (f.st == ot_pkg::F_RUN && fault && resp == `OT_RESP_DISABLE)
            |=> !output_enable_req ##1 (!output_enable_req || $past(f.timer) == 24'h000000);
    endproperty
    a_disable: assert property (p_disable) else $error("output not disabled");

    property p_hold;
        (f.st == ot_pkg::F_HOLD)
            |=> ($past(fault) ? (f.st == ot_pkg::F_HOLD && !output_enable_req) : f.st == ot_pkg::F_RUN);
    endproperty
    a_hold: assert property (p_hold) else $error("hold mode misbehaved");

    property p_noretry;
        (f.st == ot_pkg::F_DELAY && f.timer == 24'h000000 && fault && retr == `OT_RETRY_NONE)
            |=> f.st == ot_pkg::F_LATCH;
    endproperty
    a_noretry: assert property (p_noretry) else $error("restart with zero retries");

    property p_count;
        (f.st == ot_pkg::F_SPACE && on_s2 && f.timer == 24'h000000 && fault
            && retr != `OT_RETRY_CONT && 3'(f.tries + 3'h1) != retr)
            |=> f.tries == 3'($past(f.tries) + 3'h1) && f.timer == $past(retry_load);
    endproperty
    a_count: assert property (p_count) else $error("attempt not counted or spaced");

    property p_latch;
        (f.st == ot_pkg::F_LATCH && !clr) |=> f.st == ot_pkg::F_LATCH && !output_enable_req;
    endproperty
    a_latch: assert property (p_latch) else $error("latched fault left off state");

    property p_cont;
        (f.st == ot_pkg::F_SPACE && on_s2 && f.timer == 24'h000000 && fault && retr == `OT_RETRY_CONT)
            |=> f.st == ot_pkg::F_SPACE && f.tries == $past(f.tries);
    endproperty
    a_cont: assert property (p_cont) else $error("continuous retry stopped");

    property p_alert;
        fault |=> !alert_line_n && fault_status;
    endproperty
    a_alert: assert property (p_alert) else $error("fault not flagged");

endmodule

`default_nettype wire

// File: pmbus_host_model.sv
// PMBus host model that programs, clears and reads back the fault controller
`timescale 1ns/10ps
`default_nettype none

module pmbus_host_model #(
    parameter logic [6:0] ADDR = 7'h40
) (
    input  wire logic       mclk,
    input  wire logic       dut_sda_oe,
    output logic            scl,
    output logic            sda,
    output logic [7:0]      got,
    output logic            got_vld
);
    logic host_oe;

    // Pull-up on the data wire: either party pulling wins
    assign sda = !(host_oe || dut_sda_oe);

    initial begin
        scl = 1'b1;
        host_oe = 1'b0;
        got = 8'h00;
        got_vld = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ==================================================
    // Bit level
    // Data moves only while SCL is low, so no false start or stop is seen
    task automatic bit_x(input logic drv, output logic smp);
        scl = 1'b0;
        w(2);
        host_oe = drv;
        w(2);
        scl = 1'b1;
        w(2);
        smp = sda;
        w(2);
    endtask

    // Start is (0,1), stop is (1,0); SCL stays high between frames
    task automatic cond(input logic a, input logic b);
        logic s;
        bit_x(a, s);
        host_oe = b;
        w(4);
    endtask

    task automatic byte_x(input logic [7:0] d, input logic ack_drv, output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(!d[i], s);
            q[i] = s;
        end
        bit_x(ack_drv, s);
    endtask

    // ==================================================
    // Transfers
    // Word data goes low byte first; zero bytes is the clear command
    task automatic wr(input logic [7:0] cmd, input logic [15:0] data, input int n);
        logic [7:0] q;
        cond(1'b0, 1'b1);
        byte_x({ADDR, 1'b0}, 1'b0, q);
        byte_x(cmd, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            byte_x(data[8*i+:8], 1'b0, q);
        end
        cond(1'b1, 1'b0);
    endtask

    task automatic rd(input logic [7:0] cmd, input int n);
        logic [7:0] q;
        cond(1'b0, 1'b1);
        byte_x({ADDR, 1'b0}, 1'b0, q);
        byte_x(cmd, 1'b0, q);
        cond(1'b0, 1'b1);
        byte_x({ADDR, 1'b1}, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            byte_x(8'hff, i < n - 1, q);
            got = q;
            got_vld = 1'b1;
            w(1);
            got_vld = 1'b0;
        end
        cond(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// File: overtemp_fault_response_ctrl_tb.sv
// Self-checking bench for the over-temperature fault response controller
`timescale 1ns/10ps
`default_nettype none

module overtemp_fault_response_ctrl_tb;
    // Short time units keep the run brief
    localparam int DU = 20;
    localparam int RU = 16;

    logic        mclk;
    logic        reset;
    logic        scl;
    logic        sda;
    logic        sda_oe;
    logic        sda_lvl;
    logic        on_cmd;
    logic        en;
    logic        alert_n;
    logic        status;
    logic        got_vld;
    logic [15:0] temp;
    logic [7:0]  got;
    logic [7:0]  exp_q[$];
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          seed = 2513;

    overtemp_fault_response_ctrl #(
        .DELAY_UNIT_CYC(DU),
        .RETRY_UNIT_CYC(RU)
    ) overtemp_fault_response_ctrl_i (
        .mclk             (mclk),
        .reset            (reset),
        .scl_in           (scl),
        .sda_in           (sda),
        .output_on_cmd    (on_cmd),
        .temperature      (temp),
        .sda_out          (sda_lvl),
        .sda_oe           (sda_oe),
        .output_enable_req(en),
        .alert_line_n     (alert_n),
        .fault_status     (status)
    );

    pmbus_host_model pmbus_host_model_i (
        .mclk      (mclk),
        .dut_sda_oe(sda_oe),
        .scl       (scl),
        .sda       (sda),
        .got       (got),
        .got_vld   (got_vld)
    );

    always #4 mclk = ~mclk;

    // ==================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic chk(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Threshold is 128: hot covers 128..191, cool 0..127
    task automatic heat(input logic hot);
        if (hot)
            temp = 16'h0080 + 16'($unsigned($random(seed)) % 64);
        else
            temp = 16'($unsigned($random(seed)) % 128);
    endtask

    task automatic rdc(input logic [7:0] cmd, input logic [15:0] e);
        exp_q.push_back(e[7:0]);
        exp_q.push_back(e[15:8]);
        pmbus_host_model_i.rd(cmd, 2);
    endtask

    task automatic act(input logic [7:0] a);
        pmbus_host_model_i.wr(8'h50, {8'h00, a}, 1);
    endtask

    task automatic clr();
        pmbus_host_model_i.wr(8'h03, 16'h0000, 0);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================
    // Read data watcher
    always @(posedge mclk) begin
        if (got_vld === 1'b1 && exp_q.size() > 0) begin
            chk_byte(got, exp_q.pop_front());
        end
    end

    // Open drain: whenever the data pin is driven it must be driven low
    always @(negedge mclk) begin
        if (sda_oe === 1'b1) begin
            chk(sda_lvl, 1'b0);
        end
    end

    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end

    // ==================================================
    // Scenarios
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        on_cmd = 1'b1;
        temp = 16'h0010;
        tick(3);
        reset = 1'b0;
        tick(10);
        chk(en, 1'b1);
        chk(alert_n, 1'b1);
        chk(status, 1'b0);
        rdc(8'h4f, 16'h0064);
        rdc(8'h50, 16'h00c0);
        rdc(8'h99, 16'hffff);
        pmbus_host_model_i.wr(8'h4f, 16'h0080, 2);
        rdc(8'h4f, 16'h0080);
        // Exactly at the threshold already counts as a fault
        temp = 16'h0080;
        tick(3);
        chk(en, 1'b0);
        chk(alert_n, 1'b0);
        chk(status, 1'b1);
        temp = 16'h007f;
        tick(3);
        chk(en, 1'b1);
        chk(status, 1'b1);
        clr();
        tick(2);
        chk(status, 1'b0);
        act(8'h00);
        heat(1'b1);
        tick(20);
        chk(en, 1'b1);
        chk(alert_n, 1'b0);
        heat(1'b0);
        act(8'h80);
        heat(1'b1);
        tick(2);
        chk(en, 1'b0);
        heat(1'b0);
        tick(100);
        chk(en, 1'b0);
        clr();
        tick(4);
        chk(en, 1'b1);
        // One restart after two spacing units
        act(8'h8a);
        heat(1'b1);
        tick(5);
        heat(1'b0);
        tick(25);
        chk(en, 1'b0);
        tick(8);
        chk(en, 1'b1);
        act(8'h93);
        heat(1'b1);
        tick(70);
        heat(1'b0);
        tick(40);
        chk(en, 1'b1);
        act(8'h89);
        heat(1'b1);
        tick(40);
        heat(1'b0);
        tick(40);
        chk(en, 1'b0);
        clr();
        tick(4);
        chk(en, 1'b1);
        act(8'h42);
        heat(1'b1);
        tick(36);
        chk(en, 1'b1);
        tick(10);
        chk(en, 1'b0);
        heat(1'b0);
        clr();
        tick(4);
        chk(en, 1'b1);
        // Ride through one delay unit, then one restart after one spacing unit
        act(8'h49);
        heat(1'b1);
        tick(18);
        chk(en, 1'b1);
        tick(12);
        chk(en, 1'b0);
        heat(1'b0);
        tick(12);
        chk(en, 1'b1);
        act(8'hb9);
        heat(1'b1);
        tick(200);
        heat(1'b0);
        tick(40);
        chk(en, 1'b1);
        heat(1'b1);
        tick(5);
        on_cmd = 1'b0;
        tick(40);
        heat(1'b0);
        tick(20);
        chk(en, 1'b0);
        on_cmd = 1'b1;
        tick(10);
        chk(en, 1'b1);
        chk(exp_q.size() == 0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
